// ### dv/test_packet_generator_test.sv
`timescale 1ns/100ps
`default_nettype none
module test_packet_generator_test;
  logic clk_sys, rstn, psel, penable, pwrite, pready, pslverr, err;
  logic tx_valid, tx_ready;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  logic [15:0] trim_level, pa, pb, ca, cb;
  tpg_pkg::tpg_beat_s tx_beat;
  int n_mismatch, checks_done, cyc, k;

  tpg_top #(.BLOCK_FRAMES(4), .BURST_FRAMES(12), .FIFO_DEPTH(4)) i_dut (
    .clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_beat(tx_beat), .trim_level(trim_level));
  tpg_line_sink i_sink (.clk_sys(clk_sys), .rstn(rstn),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_beat(tx_beat));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 60000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input string s, input logic [31:0] v, input logic [31:0] x);
    checks_done++;
    if (v !== x) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", s, x, v);
    end
  endtask
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic int flen(input logic [1:0] c);
    case (c)
      2'h0: return 125;
      2'h1: return 64;
      2'h2: return 1518;
      default: return 10000;
    endcase
  endfunction
  // one apb transfer, held until pready is seen
  task apb(input logic w, input logic [11:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [4:0] i, input logic [15:0] d);
    apb(1'b1, {5'h00, i, 2'h0}, d);
  endtask
  task rdc(input logic [4:0] i, input logic [15:0] x);
    apb(1'b0, {5'h00, i, 2'h0}, 16'h0000);
    chk("register", rd, {16'h0000, x});
  endtask
  task wait_bytes(input int n);
    while (i_sink.q.size() < n) @(posedge clk_sys);
  endtask
  task idle_bytes(input int n);
    wait_bytes(n);
    repeat (600) @(posedge clk_sys);
    chk("byte count", i_sink.q.size(), n);
  endtask
  // checks one received frame against control word c and pattern p
  task chkf(input logic [15:0] c, input logic [15:0] p);
    int n;
    logic [31:0] f;
    logic [7:0] e;
    n = flen(c[12:11]);
    wait_bytes(n);
    f = 32'hffffffff;
    for (int i = 0; i < n - 4; i++) begin
      f = f ^ {24'h000000, i_sink.q[i][7:0]};
      repeat (8) f = f[0] ? ((f >> 1) ^ 32'hedb88320) : (f >> 1);
    end
    if (!c[0]) f = ~f;
    for (int i = 0; i < n; i++) begin
      e = (i == 5) ? {4'hf, c[9:6]} : (i == 11) ? {4'hf, c[5:2]} :
        (i < 12) ? 8'hff : (i >= n - 4) ? f[8*(i-n+4) +: 8] :
        i[0] ? p[7:0] : p[15:8];
      if (!c[1] || i < 12 || i >= n - 4)
        chk("frame byte", i_sink.q[i], {i == n - 1, e});
    end
    repeat (n) void'(i_sink.q.pop_front());
  endtask

  initial begin
    {psel, penable, pwrite, rstn} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    seed = 32'h2bf8;
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    // register map and page steering
    wr(5'h1f, 16'h0001);
    rdc(5'h1d, 16'h0040);
    rdc(5'h1e, 16'h0000);
    rdc(5'h10, 16'h0000);
    wr(5'h1f, 16'h0002);
    rdc(5'h10, 16'h028e);
    rdc(5'h1d, 16'h0000);
    rdc(5'h05, 16'h0000);
    pa = 16'(xs());
    wr(5'h10, pa);
    rdc(5'h10, pa);
    chk("trim", trim_level, pa);
    wr(5'h1f, 16'h0000);
    rdc(5'h10, 16'h0000);
    apb(1'b0, 12'h081, 16'h0000);
    chk("bad address", {rd[30:0], err}, 32'h1);
    // burst with settings changed while running
    wr(5'h1f, 16'h0001);
    ca = 16'((xs() & 32'h03fc) | 32'h0800);
    cb = 16'((xs() & 32'h03fc) | 32'h0801);
    pa = 16'(xs());
    pb = 16'(xs());
    wr(5'h1e, pa);
    wr(5'h1d, 16'hc000 | ca);
    wait_bytes(64);
    wr(5'h1d, 16'hc000 | cb);
    wr(5'h1e, pb);
    idle_bytes(768);
    repeat (12) chkf(ca, pa);
    wr(5'h1d, 16'h8000 | cb);
    wr(5'h1d, 16'hc000 | cb);
    idle_bytes(768);
    repeat (12) chkf(cb, pb);
    // continuous random payload, then stop at block end
    ca = 16'((xs() & 32'h03fc) | 32'h0802);
    wr(5'h1d, 16'h8000 | ca);
    wr(5'h1d, 16'he000 | ca);
    wait_bytes(16 * 64);
    wr(5'h1d, 16'hc000 | ca);
    repeat (900) @(posedge clk_sys);
    k = i_sink.q.size() / 64;
    chk("block end", i_sink.q.size() % 256, 0);
    chk("past burst", k >= 16, 1);
    repeat (k) chkf(ca, pb);
    // every length code, stopped by run or enable after one frame
    for (int i = 0; i < 4; i++) begin
      ca = {3'h0, i[1:0], 11'h040};
      wr(5'h1d, 16'h8000 | ca);
      wr(5'h1d, 16'hc000 | ca);
      // forced low power idle is never set, so enable may drop
      wr(5'h1d, (i[0] ? 16'h4000 : 16'h8000) | ca);
      wait_bytes(flen(i[1:0]));
      idle_bytes(flen(i[1:0]));
      chkf(ca, pb);
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ### dv/tpg_line_sink.sv
`timescale 1ns/100ps
`default_nettype none
// line side: an isolated sink, never a live network
module tpg_line_sink (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire tpg_pkg::tpg_beat_s tx_beat
);
  logic [8:0] q[$];
  logic [15:0] lf;
  // takes bytes, ready about three beats in four
  always @(posedge clk_sys) begin
    if (!rstn) begin
      lf <= 16'h5a3c;
      tx_ready <= 1'b0;
    end else begin
      lf <= {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
      tx_ready <= (lf[1:0] != 2'h0);
      if (tx_valid && tx_ready) q.push_back(tx_beat);
    end
  end
endmodule
`default_nettype wire

// ### logic/tpg_defs.svh
`ifndef TPG_DEFS_SVH
`define TPG_DEFS_SVH
// register indexes, byte address is four times the index
`define TPG_IDX_TRIM 5'h10
`define TPG_IDX_STAT 5'h1c
`define TPG_IDX_CTRL 5'h1d
`define TPG_IDX_PAT 5'h1e
`define TPG_IDX_PAGE 5'h1f
`define TPG_IDX_EXT 5'h10
// page select values
`define TPG_PAGE_STD 2'h0
`define TPG_PAGE_E1 2'h1
`define TPG_PAGE_E2 2'h2
// control field positions
`define TPG_BIT_EN 15
`define TPG_BIT_RUN 14
`define TPG_BIT_CONT 13
`define TPG_LEN_HI 12
`define TPG_LEN_LO 11
`define TPG_DA_HI 9
`define TPG_DA_LO 6
`define TPG_SA_HI 5
`define TPG_SA_LO 2
`define TPG_BIT_RND 1
`define TPG_BIT_BAD 0
// reset values
`define TPG_RST_CTRL 16'h0040
`define TPG_RST_PAT 16'h0000
`define TPG_RST_TRIM 16'h028e
// frame sizes, header byte positions and fcs length in bytes
`define TPG_LEN_00 14'h007d
`define TPG_LEN_01 14'h0040
`define TPG_LEN_10 14'h05ee
`define TPG_LEN_11 14'h2710
`define TPG_HDR_DA 14'h0005
`define TPG_HDR_SA 14'h000b
`define TPG_HDR_END 14'h000c
`define TPG_FCS_BYTES 14'h0004
// frame counts
`define TPG_BLOCK_FRAMES 10000
`define TPG_BURST_FRAMES 30000000
// crc and scrambler constants
`define TPG_CRC_POLY 32'hedb88320
`define TPG_CRC_INIT 32'hffffffff
`define TPG_LFSR_SEED 16'hace1
`endif

// ### logic/tpg_pkg.sv
`default_nettype none
package tpg_pkg;
  typedef struct packed {
    logic last;
    logic [7:0] data;
  } tpg_beat_s;
  typedef enum logic {TPG_IDLE, TPG_SEND} tpg_state_e;
  typedef struct packed {
    logic cont;
    logic [1:0] len;
    logic [3:0] da;
    logic [3:0] sa;
    logic rnd;
    logic bad;
    logic [15:0] pat;
  } tpg_cfg_s;
endpackage
`default_nettype wire

// ### logic/tpg_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "tpg_defs.svh"

module tpg_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr, rptr;
  logic [AW:0] cnt;
  logic push, pop;

  // honest full and empty from the fill count
  assign in_ready = (cnt != (AW+1)'(DEPTH));
  assign out_valid = (cnt != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rptr];

  // storage
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wptr] <= in_data;
    end
  end

  // pointers and count
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      wptr <= '0;
      rptr <= '0;
      cnt <= '0;
    end else begin
      if (push) begin
        wptr <= (wptr == AW'(DEPTH-1)) ? '0 : wptr + 1'b1;
      end
      if (pop) begin
        rptr <= (rptr == AW'(DEPTH-1)) ? '0 : rptr + 1'b1;
      end
      cnt <= cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module tpg_top #(
  parameter int BLOCK_FRAMES = `TPG_BLOCK_FRAMES,
  parameter int BURST_FRAMES = `TPG_BURST_FRAMES,
  parameter int FIFO_DEPTH = 4
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic tx_valid,
  input wire logic tx_ready,
  output tpg_pkg::tpg_beat_s tx_beat,
  output logic [15:0] trim_level
);
  localparam int BURST_BLOCKS = BURST_FRAMES / BLOCK_FRAMES;
  logic [15:0] ctrl, pat, trim, rd;
  logic [1:0] page;
  logic armed;
  tpg_pkg::tpg_state_e st;
  tpg_pkg::tpg_cfg_s snap;
  logic [13:0] idx, flen, fcs_at;
  logic [13:0] fcnt;
  logic [15:0] bcnt;
  logic [31:0] crc, next_crc, fcs;
  logic [15:0] lfsr;
  tpg_pkg::tpg_beat_s beat;
  logic push, in_ready, go, start, fend, done, wrap, in_pay;
  logic [4:0] ridx;
  logic bad_addr, wr;

  // all checks below run on the system clock, idle in reset
  default clocking cb_sys @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  // apb decode, zero wait states, error on out of range address
  assign ridx = paddr[6:2];
  assign bad_addr = (paddr[11:7] != 5'h00) || (paddr[1:0] != 2'h0);
  assign wr = psel && penable && pwrite && !bad_addr;
  assign pready = 1'b1;
  assign pslverr = psel && penable && bad_addr;
  assign trim_level = trim;

  // read mux, low registers unaffected by the page
  always_comb begin
    rd = 16'h0000;
    if (ridx == `TPG_IDX_PAGE) begin
      rd = {14'h0000, page};
    end else if (ridx >= `TPG_IDX_EXT) begin
      if (page == `TPG_PAGE_E1) begin
        if (ridx == `TPG_IDX_CTRL) rd = ctrl;
        if (ridx == `TPG_IDX_PAT) rd = pat;
        if (ridx == `TPG_IDX_STAT) rd = {st == tpg_pkg::TPG_SEND, armed,
                                         bcnt[13:0]};
      end else if (page == `TPG_PAGE_E2) begin
        if (ridx == `TPG_IDX_TRIM) rd = trim;
      end
    end
  end

  // read data captured in the setup phase
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= bad_addr ? 32'h0000_0000 : {16'h0000, rd};
    end
  end

  // page select register
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      page <= `TPG_PAGE_STD;
    end else if (wr && ridx == `TPG_IDX_PAGE) begin
      page <= pwdata[1:0];
    end
  end

  // page one generator registers
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      ctrl <= `TPG_RST_CTRL;
      pat <= `TPG_RST_PAT;
    end else if (wr && page == `TPG_PAGE_E1) begin
      if (ridx == `TPG_IDX_CTRL) ctrl <= pwdata[15:0];
      if (ridx == `TPG_IDX_PAT) pat <= pwdata[15:0];
    end
  end

  // page two amplitude trim, passed straight to the line driver
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      trim <= `TPG_RST_TRIM;
    end else if (wr && page == `TPG_PAGE_E2 && ridx == `TPG_IDX_TRIM) begin
      trim <= pwdata[15:0];
    end
  end

  // a rising run bit arms a fresh start, set wins over consume
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      armed <= 1'b0;
    end else if (wr && page == `TPG_PAGE_E1 && ridx == `TPG_IDX_CTRL &&
                 pwdata[`TPG_BIT_RUN] && !ctrl[`TPG_BIT_RUN]) begin
      armed <= 1'b1;
    end else if (start) begin
      armed <= 1'b0;
    end
  end

  // frame boundaries and the end of a run
  assign go = ctrl[`TPG_BIT_EN] && ctrl[`TPG_BIT_RUN];
  assign push = (st == tpg_pkg::TPG_SEND) && in_ready;
  assign fend = push && beat.last;
  assign start = go && armed && (st == tpg_pkg::TPG_IDLE || fend);
  assign wrap = (fcnt == 14'(BLOCK_FRAMES - 1));
  assign done = wrap && (snap.cont ? !ctrl[`TPG_BIT_CONT]
                : (bcnt + 16'h0001 == 16'(BURST_BLOCKS)));

  // run state
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      st <= tpg_pkg::TPG_IDLE;
    end else if (start) begin
      st <= tpg_pkg::TPG_SEND;
    end else if (fend && (!go || done)) begin
      st <= tpg_pkg::TPG_IDLE;
    end
  end

  // settings are frozen at each start
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      snap <= '0;
    end else if (start) begin
      snap.cont <= ctrl[`TPG_BIT_CONT];
      snap.len <= ctrl[`TPG_LEN_HI:`TPG_LEN_LO];
      snap.da <= ctrl[`TPG_DA_HI:`TPG_DA_LO];
      snap.sa <= ctrl[`TPG_SA_HI:`TPG_SA_LO];
      snap.rnd <= ctrl[`TPG_BIT_RND];
      snap.bad <= ctrl[`TPG_BIT_BAD];
      snap.pat <= pat;
    end
  end

  // frame counts, blocks of ten thousand
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      fcnt <= 14'h0000;
      bcnt <= 16'h0000;
    end else if (start) begin
      fcnt <= 14'h0000;
      bcnt <= 16'h0000;
    end else if (fend) begin
      fcnt <= wrap ? 14'h0000 : fcnt + 14'h0001;
      bcnt <= wrap ? bcnt + 16'h0001 : bcnt;
    end
  end

  // frame length lookup
  always_comb begin
    unique case (snap.len)
      2'b00: flen = `TPG_LEN_00;
      2'b01: flen = `TPG_LEN_01;
      2'b10: flen = `TPG_LEN_10;
      2'b11: flen = `TPG_LEN_11;
    endcase
  end

  assign fcs_at = flen - `TPG_FCS_BYTES;
  assign in_pay = (idx >= `TPG_HDR_END) && (idx < fcs_at);
  assign fcs = snap.bad ? crc : ~crc;

  // byte for the current position in the frame
  always_comb begin
    logic [13:0] k;
    k = idx - fcs_at;
    beat.last = (idx == flen - 14'h0001);
    beat.data = 8'hff;
    if (idx == `TPG_HDR_DA) begin
      beat.data = {4'hf, snap.da};
    end else if (idx == `TPG_HDR_SA) begin
      beat.data = {4'hf, snap.sa};
    end else if (in_pay) begin
      if (snap.rnd) beat.data = lfsr[7:0];
      else beat.data = idx[0] ? snap.pat[7:0] : snap.pat[15:8];
    end else if (idx >= fcs_at) begin
      beat.data = fcs[8*k[1:0] +: 8];
    end
  end

  // reflected crc-32 over one byte
  always_comb begin
    next_crc = crc ^ {24'h000000, beat.data};
    for (int i = 0; i < 8; i++) begin
      next_crc = next_crc[0] ? (next_crc >> 1) ^ `TPG_CRC_POLY
                             : (next_crc >> 1);
    end
  end

  // byte position, checksum and random source
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      idx <= 14'h0000;
      crc <= `TPG_CRC_INIT;
      lfsr <= `TPG_LFSR_SEED;
    end else if (start || fend) begin
      idx <= 14'h0000;
      crc <= `TPG_CRC_INIT;
    end else if (push) begin
      idx <= idx + 14'h0001;
      if (idx < fcs_at) crc <= next_crc;
      if (in_pay && snap.rnd) begin
        lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      end
    end
  end

  // bytes wait here for the line side
  tpg_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .in_valid(st == tpg_pkg::TPG_SEND),
    .in_ready(in_ready),
    .in_data(beat),
    .out_valid(tx_valid),
    .out_ready(tx_ready),
    .out_data(tx_beat)
  );

  a_idle_start: assert property (st == tpg_pkg::TPG_IDLE ##1
    st == tpg_pkg::TPG_SEND |-> $past(go) && $past(armed))
    else $error("start without run");
  // length checked against the field, not against the lookup
  a_len_last: assert property (fend |-> idx + 14'h0001 ==
    (snap.len == 2'b00 ? `TPG_LEN_00 : snap.len == 2'b01 ? `TPG_LEN_01 :
    snap.len == 2'b10 ? `TPG_LEN_10 : `TPG_LEN_11))
    else $error("bad length");
  a_da_nibble: assert property (push && idx == `TPG_HDR_DA |->
    beat.data == {4'hf, snap.da}) else $error("bad dest");
  a_sa_nibble: assert property (push && idx == `TPG_HDR_SA |->
    beat.data == {4'hf, snap.sa}) else $error("bad source");
  // odd payload end, as in 125 byte frames, runs straight into the fcs
  a_fixed_pay: assert property (push && in_pay && !snap.rnd &&
    !idx[0] |-> beat.data == snap.pat[15:8] ##1
    beat.data == snap.pat[7:0] || !push || !in_pay)
    else $error("bad pattern");
  a_cfg_frozen: assert property (!start |=> $stable(snap))
    else $error("live config");
  a_burst_end: assert property (fend && !snap.cont && done &&
    !start |=> st == tpg_pkg::TPG_IDLE) else $error("burst kept going");
  a_block_end: assert property (fend && snap.cont && !wrap && go &&
    !start |=> st == tpg_pkg::TPG_SEND) else $error("stopped mid block");
  a_page_sel: assert property (wr && ridx == `TPG_IDX_PAGE |=>
    page == $past(pwdata[1:0])) else $error("page not taken");
  a_low_regs: assert property (psel && !penable && !pwrite &&
    !bad_addr && !ridx[4] |=> prdata == 32'h0000_0000)
    else $error("low reg paged");
  c_frame_done: cover property (fend && snap.bad);
  c_jumbo: cover property (fend && snap.len == 2'b11);
  c_restart: cover property (start && st == tpg_pkg::TPG_SEND);
endmodule
`default_nettype wire
